/* include/sbrs_pkg.sv */
/*
 * Shared constants and types for the break / reset status block:
 * register indices, field positions, reset values, recovery counts.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
`default_nettype none

package sbrs_pkg;

  // APB geometry
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_OPTION_A = 16'h001f;
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] IDX_RESET_SOURCE = 16'hfe01;
  localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hfe03;
  localparam logic [15:0] IDX_SEQ_STATUS = 16'hfe05;
  localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

  // Field positions
  localparam int unsigned BIT_STOPWAIT = 1;
  localparam int unsigned BIT_CLEAR_EN = 7;
  localparam int unsigned BIT_SHORT_REC = 0;
  localparam int unsigned BIT_POR = 7;
  localparam int unsigned BIT_PIN = 6;
  localparam int unsigned BIT_WDOG = 5;
  localparam int unsigned BIT_ILLEGAL_OPCODE_RESET_FLAG = 4;
  localparam int unsigned BIT_ILLEGAL_ADDRESS_RESET_FLAG = 3;
  localparam int unsigned BIT_LVI = 1;
  localparam int unsigned BIT_IN_STOP = 0;
  localparam int unsigned BIT_RECOVER = 1;

  // Reset values
  localparam logic [REG_W-1:0] RESET_SOURCE_RST = 8'h80;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;

  // Stop recovery lengths in oscillator clock cycles
  localparam int unsigned REC_CNT_W = 13;
  localparam logic [REC_CNT_W-1:0] REC_LONG = 13'h1000;
  localparam logic [REC_CNT_W-1:0] REC_SHORT = 13'h0020;

  // Reset source event strobes, one cycle each
  typedef struct packed {
    logic pin;
    logic wdog;
    logic illegal_opcode_reset_flag;
    logic illegal_address_reset_flag;
    logic low_voltage_reset_flag;
  } sbrs_rst_src_t;

  // Low power sequencer states
  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_STOP,
    SEQ_RECOVER
  } sbrs_seq_t;

endpackage : sbrs_pkg

`default_nettype wire

/* hw/sbrs_recovery_counter.sv */
/*
 * Stop recovery counter: held clear while stopped, then counts up
 * to a limit and pulses done once.
 * Assumes start is a one-cycle strobe and limit is stable meanwhile.
 */
`timescale 1ns/100ps
`default_nettype none

module sbrs_recovery_counter #(
  parameter int unsigned W = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic start,
  input wire logic [W-1:0] limit,
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_r; // Elapsed recovery cycles
  logic busy_r; // Counting in progress
  logic done_r; // Final cycle strobe
  logic last; // Count about to reach limit

  assign last = (cnt_r == W'(limit - W'(1)));
  assign busy = busy_r;
  assign done = done_r;

  // Counter held at zero while hold is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (hold) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= W'(cnt_r + W'(1));
      busy_r <= !last;
      done_r <= last;
    end else begin
      done_r <= 1'b0;
    end
  end

endmodule : sbrs_recovery_counter

`default_nettype wire

/* hw/sbrs_top.sv */
/*
 * Break status, reset source status and break flag control logic,
 * plus the stop recovery sequencer, behind an APB slave.
 * Assumes event inputs are synchronous one-cycle strobes on pclk and
 * that presetn is the power-on reset.
 * The short recovery option must stay put while a recovery is timed.
 * Other modules may clear their flags only while flag_clear_enable is high.
 */
// What this block does
// [R1] Break in stop sets stop/wait flag
// [R2] Counter held in stop, times recovery
// [R3] Crystal systems keep short recovery cleared
// [R4] Flag reads 1 after break wake
// [R5] Flag readable by break routine
// [R6] Break status works only in emulation
// [R7] Six reset source flags held
// [R8] Reading reset status clears all flags
// [R9] Power-on sets POR, clears others
// [R10] External pin reset sets its flag
// [R11] Watchdog reset sets its flag
// [R12] Illegal opcode reset sets its flag
// [R13] Illegal address fetch sets its flag
// [R14] Low voltage reset sets its flag
// [R15] Clear enable bit gates break clearing
// [R16] Software sets enable before break clears
// [R17] Recovery 4096 cycles, 32 when short
// [R18] Break in wait sets stop/wait flag
// [R19] Flags cleared in break stay cleared
// [R20] Read returns old flags, clear next
`timescale 1ns/100ps
`default_nettype none

module sbrs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbrs_pkg::ADDR_W-1:0] paddr,
  input wire logic [sbrs_pkg::DATA_W-1:0] pwdata,
  output logic [sbrs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_exec,
  input wire logic wake_req,
  input wire logic break_irq,
  input wire logic break_state,
  input wire logic wait_mode,
  input wire logic emulation_mode,
  input wire sbrs_pkg::sbrs_rst_src_t rst_src_evt,
  output logic clocks_stopped,
  output logic recovery_active,
  output logic recovery_done,
  output logic flag_clear_enable
);
  import sbrs_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic [REG_W-1:0] option_a_r; // Option register
  logic [REG_W-1:0] break_status_r; // Break status register
  logic [REG_W-1:0] reset_source_r; // Reset source flags
  logic [REG_W-1:0] break_ctrl_r; // Break flag control register
  logic [DATA_W-1:0] prdata_r; // Registered read data
  logic pready_r; // Registered ready
  logic pslverr_r; // Registered error
  logic clear_en_r; // Break clear permission out
  logic clocks_stopped_r; // Stop state out
  logic recovery_active_r; // Recovery state out
  logic recovery_done_r; // Recovery end pulse out
  sbrs_seq_t seq_r; // Sequencer state
  sbrs_seq_t seq_nxt; // Sequencer next state

  logic setup; // APB setup phase
  logic access_done; // APB completion edge
  logic wr_done; // Completed write
  logic rd_done; // Completed read
  logic [15:0] idx; // Word index of address
  logic aligned; // Low address bits zero
  logic addr_hi_ok; // No bits above index
  logic hit_opt; // Option register decode
  logic hit_bsr; // Break status decode
  logic hit_rsr; // Reset source decode
  logic hit_bfc; // Break flag control decode
  logic hit_seq; // Sequencer status decode
  logic mapped; // Any register decoded
  logic [REG_W-1:0] rd_mux; // Read data selection
  logic [REG_W-1:0] seq_status; // Live sequencer status
  logic [REG_W-1:0] src_set; // Reset source set vector
  logic rec_start; // Recovery begins
  logic [REC_CNT_W-1:0] rec_limit; // Selected recovery length
  logic rec_busy; // Counter running
  logic rec_done; // Counter finished
  logic stopwait_set; // Break wake condition
  logic rec_hold; // Counter kept clear

  ////////////////////////////////////////////////////////////////////
  // APB decode

  // Setup and completion edges of a transfer
  assign setup = psel && !penable;
  assign access_done = psel && penable && pready_r;
  assign wr_done = access_done && pwrite;
  assign rd_done = access_done && !pwrite;
  assign idx = paddr[17:2];
  assign aligned = (paddr[1:0] == ADDR_LSB_ZERO);
  assign addr_hi_ok = (paddr[ADDR_W-1:18] == '0);

  // Word decode; misaligned or out of range addresses miss
  assign hit_opt = aligned && addr_hi_ok && (idx == IDX_OPTION_A);
  assign hit_bsr = aligned && addr_hi_ok && (idx == IDX_BREAK_STATUS);
  assign hit_rsr = aligned && addr_hi_ok && (idx == IDX_RESET_SOURCE);
  assign hit_bfc = aligned && addr_hi_ok &&
                   (idx == IDX_BREAK_FLAG_CTRL);
  assign hit_seq = aligned && addr_hi_ok && (idx == IDX_SEQ_STATUS);
  assign mapped = hit_opt || hit_bsr || hit_rsr || hit_bfc || hit_seq;

  // Live sequencer state for software
  always_comb begin
    seq_status = REG_ZERO;
    seq_status[BIT_IN_STOP] = (seq_r == SEQ_STOP);
    seq_status[BIT_RECOVER] = (seq_r == SEQ_RECOVER);
  end

  // Read data selection, unmapped reads as zero
  always_comb begin
    rd_mux = REG_ZERO;
    if (hit_opt) begin
      rd_mux = option_a_r;
    end else if (hit_bsr) begin
      rd_mux = break_status_r; // see [R5]
    end else if (hit_rsr) begin
      rd_mux = reset_source_r;
    end else if (hit_bfc) begin
      rd_mux = break_ctrl_r;
    end else if (hit_seq) begin
      rd_mux = seq_status;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer: one access cycle, no wait state

  // Ready rises for the access cycle after each setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      // No wait state: ready always follows setup by one edge
      pready_r <= setup;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      // Captured before any read clear lands
      prdata_r <= pwrite ? '0 : DATA_W'(rd_mux); // see [R20]
      pslverr_r <= !mapped;
    end else if (access_done) begin
      // Data stands for the access cycle only
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////
  // Software writable control

  // Option register holds the short recovery choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_a_r <= REG_ZERO;
    end else if (wr_done && hit_opt) begin
      // Only the short recovery bit is kept
      option_a_r <= REG_ZERO;
      option_a_r[BIT_SHORT_REC] <= pwdata[BIT_SHORT_REC]; // see [R3]
    end
  end

  // Break flag control holds the clear enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_ctrl_r <= REG_ZERO;
    end else if (wr_done && hit_bfc) begin
      // Only the clear enable bit is kept
      break_ctrl_r <= REG_ZERO;
      break_ctrl_r[BIT_CLEAR_EN] <= pwdata[BIT_CLEAR_EN]; // see [R15]
    end
  end

  // Permission to clear other modules' flags while in break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Clearing is free until break says otherwise
      clear_en_r <= 1'b1;
    end else begin
      // Outside break clearing is free; inside it needs the enable
      clear_en_r <= !break_state ||
                    break_ctrl_r[BIT_CLEAR_EN]; // see [R15] [R16] [R19]
    end
  end

  assign flag_clear_enable = clear_en_r;

  ////////////////////////////////////////////////////////////////////
  // Break status

  // Break wakes from stop or wait, emulation only
  assign stopwait_set = emulation_mode && break_irq &&
                        ((seq_r == SEQ_STOP) || wait_mode); // see [R1] [R18]

  // Stop/wait flag: set wins over a software write of zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_status_r <= REG_ZERO;
    end else if (!emulation_mode) begin
      // Nothing is kept outside emulation
      break_status_r <= REG_ZERO; // see [R6]
    end else if (stopwait_set) begin
      // Set wins over a clear in the same cycle
      break_status_r[BIT_STOPWAIT] <= 1'b1; // see [R4]
    end else if (wr_done && hit_bsr && !pwdata[BIT_STOPWAIT]) begin
      break_status_r[BIT_STOPWAIT] <= 1'b0; // see [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reset source status

  // Map reset source strobes onto flag positions
  always_comb begin
    src_set = REG_ZERO;
    src_set[BIT_PIN] = rst_src_evt.pin; // see [R10]
    src_set[BIT_WDOG] = rst_src_evt.wdog; // see [R11]
    src_set[BIT_ILLEGAL_OPCODE_RESET_FLAG] = rst_src_evt.illegal_opcode_reset_flag; // see [R12]
    src_set[BIT_ILLEGAL_ADDRESS_RESET_FLAG] = rst_src_evt.illegal_address_reset_flag; // see [R13]
    src_set[BIT_LVI] = rst_src_evt.low_voltage_reset_flag; // see [R14]
  end

  // Six source flags, cleared by read, new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Power-on leaves only its own flag
      reset_source_r <= RESET_SOURCE_RST; // see [R9]
    end else if (rd_done && hit_rsr) begin
      // Read completion clears; a strobe on this edge survives
      reset_source_r <= src_set; // see [R8] [R20]
    end else begin
      // Sources accumulate until software reads them
      reset_source_r <= reset_source_r | src_set; // see [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stop mode sequencer

  // Recovery length from the short recovery option
  assign rec_limit = option_a_r[BIT_SHORT_REC] ? REC_SHORT
                                                : REC_LONG; // see [R17]
  assign rec_start = (seq_r == SEQ_STOP) &&
                     (wake_req || break_irq);

  // Counter kept clear from stop execution until the wake edge
  assign rec_hold = (seq_r == SEQ_STOP) && !rec_start; // see [R2]

  // Next state of the stop sequencer
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      SEQ_RUN: begin
        // Stop instruction enters stop
        if (stop_exec) begin
          seq_nxt = SEQ_STOP;
        end
      end
      SEQ_STOP: begin
        // Interrupt, break or reset request wakes
        if (rec_start) begin
          seq_nxt = SEQ_RECOVER;
        end
      end
      SEQ_RECOVER: begin
        // Counter end returns to run
        if (rec_done) begin
          seq_nxt = SEQ_RUN;
        end
      end
      default: begin
        // Unused code falls back to run
        seq_nxt = SEQ_RUN;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r <= SEQ_RUN;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // Counter cleared from stop execution until recovery starts
  sbrs_recovery_counter #(
    .W(REC_CNT_W)
  ) u_rec_cnt (
    .clk(pclk),
    .rst_n(presetn),
    .hold(rec_hold), // see [R2]
    .start(rec_start), // see [R2]
    .limit(rec_limit), // see [R17]
    .busy(rec_busy),
    .done(rec_done)
  );

  // Registered sequencer outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clocks_stopped_r <= 1'b0;
      recovery_active_r <= 1'b0;
      recovery_done_r <= 1'b0;
    end else begin
      // clocks_stopped and recovery_active taken from next state so they line up with seq_r
      clocks_stopped_r <= (seq_nxt == SEQ_STOP);
      recovery_active_r <= (seq_nxt == SEQ_RECOVER) || rec_busy;
      recovery_done_r <= rec_done; // see [R17]
    end
  end

  assign clocks_stopped = clocks_stopped_r;
  assign recovery_active = recovery_active_r;
  assign recovery_done = recovery_done_r;

endmodule : sbrs_top

`default_nettype wire

/* dv/sbrs_top_sva.sv */
/* Checker for sbrs_top: APB answer timing, stop sequencer, clear enable.
   Assumes one clock domain, pclk, with presetn as its reset. */
`timescale 1ns/100ps
`default_nettype none

module sbrs_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sbrs_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_exec,
  input wire logic wake_req,
  input wire logic break_irq,
  input wire logic break_state,
  input wire logic clocks_stopped,
  input wire logic recovery_active,
  input wire logic recovery_done,
  input wire logic flag_clear_enable
);
  import sbrs_pkg::*;
  logic [12:0] since_wake_r; // Cycles since clocks restarted
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read_done;
    pready && !pwrite;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // Counts from the end of stop, saturating, to time recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wake_r <= 13'h0000;
    end else if (clocks_stopped) begin
      since_wake_r <= 13'h0000;
    end else if (since_wake_r != 13'h1fff) begin
      since_wake_r <= since_wake_r + 13'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_needs_setup: assert property
    (pready |-> $past(psel && !penable) && psel && penable)
    else $error("pready outside access");
  a_err_in_access: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  a_rdata_idle_zero: assert property
    (!(pready && !pwrite) |-> prdata == '0)
    else $error("prdata not zero");
  a_rdata_upper_zero: assert property (s_read_done |-> prdata[31:8] == '0)
    else $error("prdata upper bits set");
  a_stop_entry: assert property
    ($rose(clocks_stopped) |-> $past(stop_exec))
    else $error("stop without stop_exec");
  a_wake_leaves_stop: assert property
    (clocks_stopped && (wake_req || break_irq)
      |=> !clocks_stopped && recovery_active)
    else $error("wake not taken");
  a_stop_held: assert property
    (clocks_stopped && !wake_req && !break_irq |=> clocks_stopped)
    else $error("stop left without wake");
  a_done_single: assert property
    (recovery_done |=> !recovery_done)
    else $error("recovery_done too long");
  a_rec_length: assert property
    (recovery_done |->
      since_wake_r >= 13'h0020 && since_wake_r <= 13'h1004)
    else $error("recovery length wrong");
  a_clear_en_free: assert property
    (!break_state |=> flag_clear_enable)
    else $error("clear enable low outside break");
endmodule : sbrs_top_sva

bind sbrs_top sbrs_top_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_exec(stop_exec),
  .wake_req(wake_req), .break_irq(break_irq), .break_state(break_state),
  .clocks_stopped(clocks_stopped), .recovery_active(recovery_active),
  .recovery_done(recovery_done), .flag_clear_enable(flag_clear_enable));

`default_nettype wire

/* dv/sbrs_top_tb.sv */
/* Self-checking bench for sbrs_top: register reads, reset sources,
   break flag, stop recovery. Assumes the checker is bound beside it. */
`timescale 1ns/100ps
`default_nettype none

module sbrs_top_tb;
  import sbrs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, clocks_stopped, recovery_active;
  logic recovery_done, flag_clear_enable;
  logic stop_exec = 1'b0;
  logic wake_req = 1'b0;
  logic break_irq = 1'b0;
  logic break_state = 1'b0;
  logic wait_mode = 1'b0;
  logic emulation_mode = 1'b0;
  sbrs_rst_src_t rst_src_evt = '0;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;
  sbrs_rst_src_t ev;
  int n;

  always #50 pclk = ~pclk; // 10 MHz

  sbrs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_exec(stop_exec), .wake_req(wake_req), .break_irq(break_irq),
    .break_state(break_state), .wait_mode(wait_mode),
    .emulation_mode(emulation_mode), .rst_src_evt(rst_src_evt),
    .clocks_stopped(clocks_stopped), .recovery_active(recovery_active),
    .recovery_done(recovery_done), .flag_clear_enable(flag_clear_enable));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Expected reset source byte for a strobe set, after a clearing read
  function automatic logic [31:0] src_byte(input sbrs_rst_src_t e);
    return {24'h0, 1'b0, e.pin, e.wdog, e.illegal_opcode_reset_flag, e.illegal_address_reset_flag, 1'b0, e.low_voltage_reset_flag, 1'b0};
  endfunction : src_byte

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ADDR_W'({idx, ADDR_LSB_ZERO});
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass before the next request
    @(posedge pclk);
    if (k == 20) begin
      fails++;
      end_of_test();
    end
  endtask : apb

  // Stop, wake by break or request, then time the recovery
  task automatic stop_cycle(input logic brk, input int lo);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("clocks_stopped", 32'(clocks_stopped), 32'h1);
    apb(1'b0, IDX_SEQ_STATUS, 8'h00);
    chk("seq_in_stop", rd, 32'h1);
    if (brk) break_irq <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge pclk);
    break_irq <= 1'b0;
    wake_req <= 1'b0;
    n = 0;
    while (recovery_done !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk("recovery_len", 32'(n >= lo && n <= lo + 4), 32'h1);
  endtask : stop_cycle

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    void'($urandom(81));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDX_RESET_SOURCE, 8'h00);
    chk("src_por", rd, 32'h80);
    apb(1'b0, IDX_RESET_SOURCE, 8'h00);
    chk("src_cleared", rd, 32'h0);
    for (int i = 0; i < 10; i++) begin
      ev = (i == 0) ? 5'h1f : 5'($urandom);
      rst_src_evt <= ev;
      @(posedge pclk);
      rst_src_evt <= '0;
      apb(1'b0, IDX_RESET_SOURCE, 8'h00);
      chk("src_flags", rd, src_byte(ev));
      apb(1'b0, IDX_RESET_SOURCE, 8'h00);
      chk("src_read_clear", rd, 32'h0);
    end
    // Power-on in mid-run: all five strobe-set source flags set first, then reset
    rst_src_evt <= 5'h1f;
    @(posedge pclk);
    rst_src_evt <= '0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst_clear_en", 32'(flag_clear_enable), 32'h1);
    chk("rst_stopped", 32'(clocks_stopped), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDX_RESET_SOURCE, 8'h00);
    chk("src_por_again", rd, 32'h80);
    // Enable is set before any clearing in break
    break_state <= 1'b1;
    apb(1'b1, IDX_BREAK_FLAG_CTRL, 8'h80);
    apb(1'b0, IDX_BREAK_FLAG_CTRL, 8'h00);
    chk("clear_en_rd", rd, 32'h80);
    chk("clear_en_pin", 32'(flag_clear_enable), 32'h1);
    apb(1'b1, IDX_BREAK_FLAG_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    chk("clear_en_off", 32'(flag_clear_enable), 32'h0);
    break_state <= 1'b0;
    apb(1'b0, 16'h0100, 8'h00);
    chk("unmapped_err", 32'(err), 32'h1);
    // Break during wait, with and without emulation
    wait_mode <= 1'b1;
    for (int m = 1; m >= 0; m--) begin
      emulation_mode <= m[0];
      break_irq <= 1'b1;
      @(posedge pclk);
      break_irq <= 1'b0;
      apb(1'b0, IDX_BREAK_STATUS, 8'h00);
      chk("bsw_wait", rd, m[0] ? 32'h2 : 32'h0);
      apb(1'b1, IDX_BREAK_STATUS, 8'h00);
      apb(1'b0, IDX_BREAK_STATUS, 8'h00);
      chk("bsw_clr", rd, 32'h0);
    end
    wait_mode <= 1'b0;
    emulation_mode <= 1'b1;
    apb(1'b1, IDX_OPTION_A, 8'h01);
    stop_cycle(1'b1, 32);
    apb(1'b0, IDX_BREAK_STATUS, 8'h00);
    chk("bsw_stop", rd, 32'h2);
    // Full recovery, as a crystal system keeps it
    apb(1'b1, IDX_OPTION_A, 8'h00);
    stop_cycle(1'b0, 4096);
    end_of_test();
  end
endmodule : sbrs_top_tb

`default_nettype wire
